// [include/rtci_pkg.sv]
/*
  rtci_pkg: constants, register map, field positions and shared helpers
  of the clock status and time-register block.
  Assumes a 100 MHz system clock and BCD-coded time registers.
*/
package rtci_pkg;

  localparam int CLK_HZ = 100_000_000;

  // register offsets (byte pointer of the serial bus)
  localparam logic [7:0] REG_CTRL = 8'h01;
  localparam logic [7:0] REG_SEC = 8'h02;
  localparam logic [7:0] REG_MIN = 8'h03;
  localparam logic [7:0] REG_HOUR = 8'h04;
  localparam logic [7:0] REG_DAY = 8'h05;

  // field positions
  localparam int CTL_PSEL_BIT = 4;
  localparam int CTL_AF_BIT = 3;
  localparam int CTL_TF_BIT = 2;
  localparam int CTL_AIE_BIT = 1;
  localparam int CTL_TIE_BIT = 0;
  localparam int SEC_SL_BIT = 7;

  // bcd limits
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MIN_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] DAY_FIRST = 8'h01;
  localparam logic [7:0] DAY_28 = 8'h28;
  localparam logic [7:0] DAY_29 = 8'h29;
  localparam logic [7:0] DAY_30 = 8'h30;
  localparam logic [7:0] DAY_31 = 8'h31;
  localparam logic [4:0] MON_FEB = 5'h02;
  localparam logic [4:0] MON_APR = 5'h04;
  localparam logic [4:0] MON_JUN = 5'h06;
  localparam logic [4:0] MON_SEP = 5'h09;
  localparam logic [4:0] MON_NOV = 5'h11;

  // countdown source codes
  localparam logic [1:0] SRC_4096 = 2'h0;
  localparam logic [1:0] SRC_64 = 2'h1;
  localparam logic [1:0] SRC_1 = 2'h2;
  localparam logic [1:0] SRC_60 = 2'h3;

  // interrupt pulse lengths, as 1/N seconds
  localparam int PW_DIV_8192 = 8192;
  localparam int PW_DIV_4096 = 4096;
  localparam int PW_DIV_128 = 128;
  localparam int PW_DIV_64 = 64;
  localparam int PW_W = 21;

  // serial bus
  localparam logic [6:0] DEF_SLAVE_ADDR = 7'h32; // arbitrary value
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] CDN_ONE = 8'h01;

  // synchronised pin indices
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_VLOW = 2;
  localparam int PIN_OSTOP = 3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
  } rtci_bus_st_t;

  // one bcd step: {wrap, next}; values at or above the limit wrap, so an
  // out-of-range write recovers at the next step
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] maxv,
                                          input logic [7:0] first);
    if (v >= maxv) begin
      return {1'b1, first};
    end else if (v[3:0] >= BCD_NINE) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      return {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction

endpackage

// [hw/rtci_evt_sync.sv]
/*
  rtci_evt_sync: carries one-cycle events from a source clock to a
  destination clock by toggles and a three-stage capture.
  Assumes events in one lane are at least four destination cycles apart.
*/
`timescale 1ns/1ns
module rtci_evt_sync
  import rtci_pkg::*;
#(
  parameter int N = 2
) (
  // source side
  input wire logic i_src_clk,
  input wire logic [N-1:0] i_src_pulse,
  // destination side
  input wire logic i_dst_clk,
  output logic [N-1:0] o_dst_pulse,
  // reset
  input wire logic i_nrst
);
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
  } rtci_sync_st_t;

  logic [N-1:0] tgl_r;
  logic [N-1:0] tgl_nxt;
  rtci_sync_st_t d_r;
  rtci_sync_st_t d_nxt;

  always_comb begin
    tgl_nxt = tgl_r ^ i_src_pulse;
    d_nxt.s1 = tgl_r;
    d_nxt.s2 = d_r.s1;
    d_nxt.s3 = d_r.s2;
  end

  always_ff @(posedge i_src_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tgl_r <= '0;
    end else begin
      tgl_r <= tgl_nxt;
    end
  end

  always_ff @(posedge i_dst_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      d_r <= '0;
    end else begin
      d_r <= d_nxt;
    end
  end

  // s1 feeds s2 only; the edge is seen between the two later stages
  assign o_dst_pulse = d_r.s2 ^ d_r.s3;

endmodule

// [hw/rtci_cdown.sv]
/*
  rtci_cdown: countdown counter on the oscillator clock, with done pulse
  and the source and n=1 facts captured for the interrupt pulse width.
  Assumes load and source tick are one-cycle pulses on i_osc_clk.
*/
`timescale 1ns/1ns
module rtci_cdown
  import rtci_pkg::*;
(
  // clock and reset
  input wire logic i_osc_clk,
  input wire logic i_nrst,
  // control
  input wire logic i_load,
  input wire logic [7:0] i_value,
  input wire logic [1:0] i_src,
  input wire logic i_src_tick,
  // result
  output logic o_done,
  output logic [1:0] o_src_cap,
  output logic o_one_cap
);
  typedef struct packed {
    logic [7:0] cnt;
    logic one_load;
    logic done;
    logic [1:0] src_cap;
    logic one_cap;
  } rtci_cdn_st_t;

  rtci_cdn_st_t r;
  rtci_cdn_st_t n;

  always_comb begin
    n = r;
    n.done = 1'b0;
    if (i_load) begin
      n.cnt = i_value;
      n.one_load = (i_value == CDN_ONE);
    end else if (i_src_tick && (r.cnt != BCD_ZERO)) begin
      n.cnt = r.cnt - CDN_ONE; // stops once zero is reached [RQ11]
      if (r.cnt == CDN_ONE) begin
        n.done = 1'b1;
        n.src_cap = i_src;
        n.one_cap = r.one_load;
      end
    end
  end

  always_ff @(posedge i_osc_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_done = r.done;
  assign o_src_cap = r.src_cap;
  assign o_one_cap = r.one_cap;

  AST_CDN_STOP: assert property (@(posedge i_osc_clk) disable iff (!i_nrst) // [RQ11]
    (r.cnt == BCD_ZERO) && !i_load |=> (r.cnt == BCD_ZERO) && !r.done)
    else $error("countdown moved past zero");

endmodule

// [hw/rtci_top.sv]
/*
  rtci_top: two-wire bus slave with interrupt control/status, supply-low
  flag and the seconds, minutes, hours and day time registers.
  Assumes the bus master, a 1 Hz tick and countdown source on i_osc_clk,
  and month/year values supplied by the neighbouring calendar logic.
*/
//
// Contract
// [RQ1] pulse-select 0: interrupt held while countdown flag and its enable are set
// [RQ2] pulse-select 1: countdown gives enabled pulses; enabled alarm flag still holds interrupt
// [RQ3] alarm condition sets the alarm flag at bit 3
// [RQ4] countdown end sets the countdown flag at bit 2
// [RQ5] flags hold until the master overwrites them
// [RQ6] writes AND each flag with the written bit
// [RQ7] bit 1 alarm enable, bit 0 countdown enable; interrupt is OR of both
// [RQ8] 4096 Hz source: pulse 1/8192 s for n=1, else 1/4096 s
// [RQ9] 64 Hz source: pulse 1/128 s for n=1, else 1/64 s
// [RQ10] 1 Hz or 1/60 Hz source: pulse 1/64 s always
// [RQ11] countdown stops when it reaches zero
// [RQ12] master writes zero to bits 7..5; register resets to zero
// [RQ13] supply low or oscillator stop sets bit 7 of seconds; one after start-up
// [RQ14] only a bus write clears the supply-low flag
// [RQ15] seconds in bcd: tens bits 6..4, units bits 3..0
// [RQ16] minutes in bcd: tens bits 6..4, units 3..0, bit 7 unused
// [RQ17] hours 24-hour bcd: tens bits 5..4, units 3..0
// [RQ18] day in bcd: tens bits 5..4, units 3..0
// [RQ19] february has 29 days when year divisible by four, 00 included
// [RQ20] time counters freeze during a bus access
// [RQ21] one increment is held during access; master finishes within one second
// [RQ22] seconds wrap 59 to 00 and carry into minutes, hours, days
// [RQ23] interrupt output active low open drain, released when no condition
`timescale 1ns/1ns
module rtci_top
  import rtci_pkg::*;
#(
  parameter logic [6:0] P_SLAVE_ADDR = DEF_SLAVE_ADDR,
  parameter int P_PW_8192_CYC = CLK_HZ / PW_DIV_8192,
  parameter int P_PW_4096_CYC = CLK_HZ / PW_DIV_4096,
  parameter int P_PW_128_CYC = CLK_HZ / PW_DIV_128,
  parameter int P_PW_64_CYC = CLK_HZ / PW_DIV_64
) (
  // clocks and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_osc_clk,
  // two-wire bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // interrupt pin
  output logic o_int_n_o,
  output logic o_int_n_oe,
  // supply monitor pins
  input wire logic i_supply_low,
  input wire logic i_osc_stopped,
  // oscillator-domain tick and countdown
  input wire logic i_sec_tick,
  input wire logic i_tmr_load,
  input wire logic [7:0] i_tmr_value,
  input wire logic [1:0] i_tmr_src,
  input wire logic i_tmr_src_tick,
  // calendar neighbours
  input wire logic i_alarm_match,
  input wire logic [4:0] i_month_bcd,
  input wire logic [7:0] i_year_bcd,
  output logic o_day_wrap
);
  localparam logic [PW_W-1:0] PW_8192_C = PW_W'(P_PW_8192_CYC);
  localparam logic [PW_W-1:0] PW_4096_C = PW_W'(P_PW_4096_CYC);
  localparam logic [PW_W-1:0] PW_128_C = PW_W'(P_PW_128_CYC);
  localparam logic [PW_W-1:0] PW_64_C = PW_W'(P_PW_64_CYC);
  localparam logic [PW_W-1:0] PW_ONE = PW_W'(1);

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] filt;
    logic [1:0] prev;
    rtci_bus_st_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic first;
    logic ack;
    logic [7:0] ptr;
    logic busy;
    logic pend;
    logic psel;
    logic af;
    logic tf;
    logic alarm_irq_enable;
    logic countdown_irq_enable;
    logic sl;
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hour;
    logic [5:0] day;
    logic [PW_W-1:0] pw_cnt;
    logic int_oe;
    logic sda_oe;
    logic drv_lo;
    logic day_wrap;
  } rtci_top_st_t;

  rtci_top_st_t r;
  rtci_top_st_t n;
  logic [1:0] evt;
  logic cdn_done;
  logic [1:0] cdn_src;
  logic cdn_one;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic tick_evt;
  logic done_evt;

  rtci_cdown u_cdown (
    .i_osc_clk(i_osc_clk),
    .i_nrst(i_nrst),
    .i_load(i_tmr_load),
    .i_value(i_tmr_value),
    .i_src(i_tmr_src),
    .i_src_tick(i_tmr_src_tick),
    .o_done(cdn_done),
    .o_src_cap(cdn_src),
    .o_one_cap(cdn_one)
  );

  // src/one captures are held from done until the next done, so they are
  // stable long before the synchronised event samples them
  rtci_evt_sync #(.N(2)) u_evt_sync (
    .i_src_clk(i_osc_clk),
    .i_src_pulse({cdn_done, i_sec_tick}),
    .i_dst_clk(i_clk),
    .o_dst_pulse(evt),
    .i_nrst(i_nrst)
  );

  assign tick_evt = evt[0];
  assign done_evt = evt[1];

  function automatic logic [7:0] month_len(input logic [4:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? ((y[3:0] == 4'h2) || (y[3:0] == 4'h6))
                : ((y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8)); // [RQ19]
    if (m == MON_FEB) begin
      return leap ? DAY_29 : DAY_28;
    end else if ((m == MON_APR) || (m == MON_JUN) || (m == MON_SEP) || (m == MON_NOV)) begin
      return DAY_30;
    end else begin
      return DAY_31;
    end
  endfunction

  // unmapped pointers read as zero; reserved bits read as zero
  function automatic logic [7:0] rd_reg(input rtci_top_st_t s);
    logic [7:0] b;
    b = BCD_ZERO;
    unique case (s.ptr)
      REG_CTRL: begin
        b[CTL_PSEL_BIT] = s.psel; // [RQ12]
        b[CTL_AF_BIT] = s.af;
        b[CTL_TF_BIT] = s.tf;
        b[CTL_AIE_BIT] = s.alarm_irq_enable;
        b[CTL_TIE_BIT] = s.countdown_irq_enable;
      end
      REG_SEC: b = {s.sl, s.sec}; // [RQ15]
      REG_MIN: b = {1'b0, s.min}; // [RQ16]
      REG_HOUR: b = {2'b00, s.hour}; // [RQ17]
      REG_DAY: b = {2'b00, s.day}; // [RQ18]
      default: b = BCD_ZERO;
    endcase
    return b;
  endfunction

  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic adv;
    logic [7:0] eq;
    logic [7:0] rb;
    logic [8:0] s_sec;
    logic [8:0] s_min;
    logic [8:0] s_hour;
    logic [8:0] s_day;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    adv = 1'b0;
    eq = '0;
    rb = rd_reg(r);
    s_sec = bcd_step({1'b0, r.sec}, SEC_MAX, BCD_ZERO);
    s_min = bcd_step({1'b0, r.min}, MIN_MAX, BCD_ZERO);
    s_hour = bcd_step({2'b00, r.hour}, HOUR_MAX, BCD_ZERO);
    s_day = bcd_step({2'b00, r.day}, month_len(i_month_bcd, i_year_bcd), DAY_FIRST);
    n = r;
    wr_stb = 1'b0;
    wr_addr = r.ptr;

    // a pin change counts once the second and third stages agree
    n.sync1 = {i_osc_stopped, i_supply_low, i_sda, i_scl};
    n.sync2 = r.sync1;
    n.sync3 = r.sync2;
    eq[3:0] = ~(r.sync2 ^ r.sync3);
    n.filt = (eq[3:0] & r.sync3) | (~eq[3:0] & r.filt);
    n.prev = {r.filt[PIN_SDA], r.filt[PIN_SCL]};
    scl_rise = r.filt[PIN_SCL] & ~r.prev[0];
    scl_fall = ~r.filt[PIN_SCL] & r.prev[0];
    start = r.filt[PIN_SCL] & r.prev[0] & ~r.filt[PIN_SDA] & r.prev[1];
    stop = r.filt[PIN_SCL] & r.prev[0] & r.filt[PIN_SDA] & ~r.prev[1];
    n.day_wrap = 1'b0;

    if (start) begin
      n.st = ST_ADDR;
      n.bitcnt = '0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.st = ST_IDLE;
      n.sda_oe = 1'b0;
      n.busy = 1'b0;
    end else begin
      unique case (r.st)
        ST_IDLE: begin
          n.sda_oe = 1'b0;
        end
        ST_ADDR, ST_WDATA: begin
          if (scl_rise) begin
            n.shreg = {r.shreg[6:0], r.filt[PIN_SDA]};
            n.bitcnt = r.bitcnt + 4'h1;
          end
          if (scl_fall && (r.bitcnt == BYTE_BITS)) begin
            if (r.st == ST_ADDR) begin
              if (r.shreg[7:1] == P_SLAVE_ADDR) begin
                n.st = ST_AACK;
                n.sda_oe = 1'b1;
                n.rw = r.shreg[0];
                n.first = ~r.shreg[0];
                n.busy = 1'b1;
              end else begin
                n.st = ST_IDLE;
                n.busy = 1'b0;
              end
            end else begin
              n.st = ST_WACK;
              n.sda_oe = 1'b1;
              n.first = 1'b0;
              if (r.first) begin
                n.ptr = r.shreg;
              end else begin
                wr_stb = 1'b1;
                n.ptr = r.ptr + 8'h01;
              end
            end
          end
        end
        ST_AACK, ST_WACK, ST_RACK: begin
          if (scl_rise) begin
            n.ack = ~r.filt[PIN_SDA];
          end
          if (scl_fall) begin
            n.bitcnt = '0;
            n.sda_oe = 1'b0;
            if ((r.st == ST_RACK) ? r.ack : ((r.st == ST_AACK) && r.rw)) begin
              n.st = ST_RDATA;
              n.sda_oe = ~rb[7];
              n.shreg = {rb[6:0], 1'b0};
              n.ptr = r.ptr + 8'h01;
            end else if (r.st == ST_RACK) begin
              n.st = ST_IDLE;
            end else begin
              n.st = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            n.bitcnt = r.bitcnt + 4'h1;
          end
          if (scl_fall) begin
            if (r.bitcnt == BYTE_BITS) begin
              n.st = ST_RACK;
              n.sda_oe = 1'b0;
            end else begin
              n.sda_oe = ~r.shreg[7];
              n.shreg = {r.shreg[6:0], 1'b0};
            end
          end
        end
        default: begin
          n.st = ST_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end

    // counters frozen while addressed; one tick is kept for later
    if (r.busy) begin
      n.pend = r.pend | tick_evt; // [RQ20] [RQ21]
    end else begin
      adv = tick_evt | r.pend;
      n.pend = r.pend & tick_evt; // [RQ21]
    end
    if (adv) begin
      n.sec = s_sec[6:0]; // [RQ22]
      if (s_sec[8]) begin
        n.min = s_min[6:0];
        if (s_min[8]) begin
          n.hour = s_hour[5:0];
          if (s_hour[8]) begin
            n.day = s_day[5:0];
            n.day_wrap = s_day[8];
          end
        end
      end
    end

    if (wr_stb) begin
      unique case (wr_addr)
        REG_CTRL: begin
          n.psel = r.shreg[CTL_PSEL_BIT];
          n.af = r.af & r.shreg[CTL_AF_BIT]; // [RQ6]
          n.tf = r.tf & r.shreg[CTL_TF_BIT]; // [RQ6]
          n.alarm_irq_enable = r.shreg[CTL_AIE_BIT];
          n.countdown_irq_enable = r.shreg[CTL_TIE_BIT];
        end
        REG_SEC: begin
          n.sl = r.shreg[SEC_SL_BIT]; // [RQ14]
          n.sec = r.shreg[6:0]; // [RQ15]
        end
        REG_MIN: n.min = r.shreg[6:0]; // [RQ16]
        REG_HOUR: n.hour = r.shreg[5:0]; // [RQ17]
        REG_DAY: n.day = r.shreg[5:0]; // [RQ18]
        default: n.ptr = n.ptr;
      endcase
    end

    // a hardware event wins over a clearing write in the same cycle
    if (i_alarm_match) begin
      n.af = 1'b1; // [RQ3] [RQ5]
    end
    if (done_evt) begin
      n.tf = 1'b1; // [RQ4] [RQ5]
    end
    if (r.filt[PIN_VLOW] | r.filt[PIN_OSTOP]) begin
      n.sl = 1'b1; // [RQ13]
    end

    if (done_evt && r.psel) begin
      unique case (cdn_src)
        SRC_4096: n.pw_cnt = cdn_one ? PW_8192_C : PW_4096_C; // [RQ8]
        SRC_64: n.pw_cnt = cdn_one ? PW_128_C : PW_64_C; // [RQ9]
        SRC_1, SRC_60: n.pw_cnt = PW_64_C; // [RQ10]
      endcase
    end else if (r.pw_cnt != '0) begin
      n.pw_cnt = r.pw_cnt - PW_ONE;
    end

    // pin pulled low while any enabled condition stands [RQ23]
    n.int_oe = (n.af & n.alarm_irq_enable) | (n.tf & n.countdown_irq_enable & ~n.psel) | ((n.pw_cnt != '0) & n.countdown_irq_enable); // [RQ1] [RQ2] [RQ7]
    n.drv_lo = 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r <= '0; // [RQ12]
      r.sl <= 1'b1; // [RQ13]
    end else begin
      r <= n;
    end
  end

  assign o_sda_o = r.drv_lo;
  assign o_sda_oe = r.sda_oe;
  assign o_int_n_o = r.drv_lo;
  assign o_int_n_oe = r.int_oe;
  assign o_day_wrap = r.day_wrap;

  AST_INT_LEVEL: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RQ1]
    (r.tf && r.countdown_irq_enable && !r.psel) |-> o_int_n_oe)
    else $error("level interrupt missing with countdown flag set");
  AST_ALARM_HOLD: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RQ2]
    (r.af && r.alarm_irq_enable) |-> o_int_n_oe)
    else $error("enabled alarm flag does not hold the interrupt");
  AST_INT_RELEASE: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RQ7]
    !(r.af && r.alarm_irq_enable) && !(r.tf && r.countdown_irq_enable && !r.psel) && ((r.pw_cnt == '0) || !r.countdown_irq_enable) |-> !o_int_n_oe)
    else $error("interrupt driven with no enabled condition");
  AST_AF_SET: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RQ3]
    i_alarm_match |=> r.af)
    else $error("alarm flag not set");
  AST_TF_SET: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RQ4]
    done_evt |=> r.tf && (r.psel || !r.countdown_irq_enable || o_int_n_oe))
    else $error("countdown flag not set");
  AST_FLAG_KEEP: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RQ5]
    r.af && !(wr_stb && (wr_addr == REG_CTRL)) |=> r.af)
    else $error("alarm flag lost without a write");
  AST_AND_CLEAR: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RQ6]
    wr_stb && (wr_addr == REG_CTRL) && !r.shreg[CTL_TF_BIT] && !done_evt && $stable(r.af) |=> !r.tf)
    else $error("write of zero did not clear countdown flag");
  AST_PULSE_8192: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RQ8]
    done_evt && r.psel && (cdn_src == SRC_4096) && cdn_one |=> (r.pw_cnt == PW_8192_C))
    else $error("wrong pulse length for 4096 Hz, n=1");
  AST_PULSE_64: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RQ10]
    done_evt && r.psel && ((cdn_src == SRC_1) || (cdn_src == SRC_60)) |=> (r.pw_cnt == PW_64_C))
    else $error("wrong pulse length for slow source");
  AST_SL_KEEP: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RQ14]
    r.sl && !(wr_stb && (wr_addr == REG_SEC)) |=> r.sl)
    else $error("supply-low flag cleared without a write");
  AST_FREEZE: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RQ20]
    r.busy && !wr_stb |=> $stable(r.sec) && $stable(r.min))
    else $error("time counters moved during an access");
  AST_SEC_WRAP: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RQ22]
    !r.busy && tick_evt && !r.pend && ({1'b0, r.sec} == SEC_MAX) && !wr_stb |=> (r.sec == '0))
    else $error("seconds did not wrap to zero");

endmodule

// [dv/rtci_bus_master.sv]
/*
  rtci_bus_master: two-wire bus master model with single-byte write and read tasks.
  Assumes the bench resolves the open-drain data line, pulled up when released.
*/
`timescale 1ns/1ns
module rtci_bus_master
  import rtci_pkg::*;
(
  // clock and resolved line
  input wire logic i_clk,
  input wire logic i_sda,
  // driven levels, 1 = released
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // 12 cycles a half bit stays clear of the 8-cycle minimum
  task automatic hw();
    repeat (12) @(posedge i_clk);
    #1;
  endtask
  task automatic bitx(input logic b, output logic r);
    o_sda = b;
    hw();
    o_scl = 1'b1;
    hw();
    r = i_sda;
    o_scl = 1'b0;
  endtask
  task automatic start();
    o_sda = 1'b1;
    hw();
    o_scl = 1'b1;
    hw();
    o_sda = 1'b0;
    hw();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    o_sda = 1'b0;
    hw();
    o_scl = 1'b1;
    hw();
    o_sda = 1'b1;
    hw();
  endtask
  task automatic bytex(input logic [7:0] d, input logic a, output logic [7:0] q);
    logic k;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(a, k);
  endtask
  // a single-byte access lasts under 1000 cycles, far below one tick period
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    start();
    bytex({DEF_SLAVE_ADDR, 1'b0}, 1'b1, q);
    bytex(p, 1'b1, q);
    bytex(d, 1'b1, q);
    stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] q);
    start();
    bytex({DEF_SLAVE_ADDR, 1'b0}, 1'b1, q);
    bytex(p, 1'b1, q);
    start();
    bytex({DEF_SLAVE_ADDR, 1'b1}, 1'b1, q);
    bytex(8'hff, 1'b1, q);
    stop();
  endtask
  // two-byte read: the first byte is acked, the second refused
  task automatic rd2(input logic [7:0] p, output logic [15:0] q);
    logic [7:0] t;
    start();
    bytex({DEF_SLAVE_ADDR, 1'b0}, 1'b1, t);
    bytex(p, 1'b1, t);
    start();
    bytex({DEF_SLAVE_ADDR, 1'b1}, 1'b1, t);
    bytex(8'hff, 1'b0, q[15:8]);
    bytex(8'hff, 1'b1, q[7:0]);
    stop();
  endtask
endmodule

// [dv/rtci_top_bench.sv]
/*
  rtci_top_bench: self-checking bench for the status and time registers.
  Assumes rtci_bus_master for bus traffic and shortened pulse-width parameters.
*/
`timescale 1ns/1ns
module rtci_top_bench
  import rtci_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_osc_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic scl, m_sda, sda_o, sda_oe, sda_ln, int_en, int_o, int_oe, dwrap;
  logic sup_low = 1'b0, osc_stop = 1'b0, tick = 1'b0, ld = 1'b0, stk = 1'b0, alarm = 1'b0;
  logic [7:0] tval = 8'h00, year = 8'h00, q;
  logic [1:0] tsrc = 2'h0;
  logic [4:0] month = 5'h01;
  int err_total = 0;
  int comparisons = 0;
  int w;
  int wraps = 0;
  logic [15:0] b2;
  // bits 7..5 of every control write are zero
  logic [7:0] tab [6][3] = '{'{8'h01, 8'h13, 8'h13}, '{8'h02, 8'h45, 8'h45}, '{8'h03, 8'h59, 8'h59},
                             '{8'h04, 8'h23, 8'h23}, '{8'h05, 8'h31, 8'h31}, '{8'h07, 8'h5a, 8'h00}};
  logic [7:0] pw [4][2] = '{'{8'h14, 8'h28}, '{8'h3c, 8'h50}, '{8'h50, 8'h50}, '{8'h50, 8'h50}};
  logic [7:0] wv [4] = '{8'h59, 8'h59, 8'h23, 8'h28};
  logic [7:0] yr [3] = '{8'h04, 8'h00, 8'h01};
  logic [7:0] dexp [3] = '{8'h29, 8'h29, 8'h01};

  always #5 i_clk = ~i_clk;
  // oscillator clock, 125 ns, no phase relation to i_clk
  always begin
    #62 i_osc_clk = 1'b1;
    #63 i_osc_clk = 1'b0;
  end
  // a driven pin shows the design's output level, a released one its pull-up
  assign sda_ln = m_sda & (~sda_oe | sda_o);
  assign int_oe = int_en & ~int_o;
  always @(posedge i_clk) wraps += dwrap;

  rtci_bus_master rtci_bus_master_inst (.i_clk(i_clk), .i_sda(sda_ln), .o_scl(scl), .o_sda(m_sda));
  rtci_top #(.P_PW_8192_CYC(20), .P_PW_4096_CYC(40), .P_PW_128_CYC(60), .P_PW_64_CYC(80)) rtci_top_inst (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_osc_clk(i_osc_clk), .i_scl(scl), .i_sda(sda_ln),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_int_n_o(int_o), .o_int_n_oe(int_en), .i_supply_low(sup_low),
    .i_osc_stopped(osc_stop), .i_sec_tick(tick), .i_tmr_load(ld), .i_tmr_value(tval), .i_tmr_src(tsrc),
    .i_tmr_src_tick(stk), .i_alarm_match(alarm), .i_month_bcd(month), .i_year_bcd(year), .o_day_wrap(dwrap));

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] p, input logic [7:0] e);
    rtci_bus_master_inst.rd(p, q);
    chk(e, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic osc(ref logic s);
    @(posedge i_osc_clk);
    #1 s = 1'b1;
    @(posedge i_osc_clk);
    #1 s = 1'b0;
  endtask
  task automatic cdown(input logic [7:0] n, input logic [1:0] s);
    tsrc = s;
    tval = n;
    osc(ld);
    repeat (n) osc(stk);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge i_clk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    cyc(10);
    i_nrst = 1'b1;
    cyc(20);
    chk(8'h00, {7'h00, int_oe});
    rchk(REG_CTRL, 8'h00);
    rchk(REG_SEC, 8'h80);
    for (int i = 0; i < 6; i++) begin
      rtci_bus_master_inst.wr(tab[i][0], tab[i][1]);
      rchk(tab[i][0], tab[i][2]);
    end
    // flags: alarm then countdown, cleared one at a time
    rtci_bus_master_inst.wr(REG_CTRL, 8'h02);
    alarm = 1'b1;
    cyc(1);
    alarm = 1'b0;
    cyc(3);
    chk(8'h01, {7'h00, int_oe});
    cdown(8'h02, SRC_4096);
    rchk(REG_CTRL, 8'h0e);
    rtci_bus_master_inst.wr(REG_CTRL, 8'h0b);
    rchk(REG_CTRL, 8'h0b);
    rtci_bus_master_inst.wr(REG_CTRL, 8'h03);
    rchk(REG_CTRL, 8'h03);
    chk(8'h00, {7'h00, int_oe});
    // level mode holds while the flag stands; spent timer gives no second event
    cdown(8'h01, SRC_64);
    cyc(200);
    chk(8'h01, {7'h00, int_oe});
    rtci_bus_master_inst.wr(REG_CTRL, 8'h03);
    osc(stk);
    osc(stk);
    cyc(10);
    chk(8'h00, {7'h00, int_oe});
    rchk(REG_CTRL, 8'h03);
    // pulsed mode widths over every source and n = 1, 2
    rtci_bus_master_inst.wr(REG_CTRL, 8'h11);
    for (int s = 0; s < 4; s++) begin
      for (int n = 1; n < 3; n++) begin
        cdown(n[7:0], s[1:0]);
        w = 0;
        for (int k = 0; k < 200; k++) begin
          cyc(1);
          w += (int_oe === 1'b1);
        end
        chk(pw[s][n-1], w[7:0]);
      end
    end
    // pulsed mode: an enabled alarm flag still holds the line
    rtci_bus_master_inst.wr(REG_CTRL, 8'h13);
    alarm = 1'b1;
    cyc(1);
    alarm = 1'b0;
    cyc(200);
    chk(8'h01, {7'h00, int_oe});
    rtci_bus_master_inst.wr(REG_CTRL, 8'h00);
    // both supply pins set the flag; it holds until written
    for (int i = 0; i < 2; i++) begin
      sup_low = (i == 0);
      osc_stop = (i == 1);
      cyc(10);
      sup_low = 1'b0;
      osc_stop = 1'b0;
      rchk(REG_SEC, 8'hc5);
      rchk(REG_SEC, 8'hc5);
      rtci_bus_master_inst.wr(REG_SEC, 8'h45);
    end
    rchk(REG_SEC, 8'h45);
    // full carry chain into february, leap and common years
    month = MON_FEB;
    for (int i = 0; i < 3; i++) begin
      year = yr[i];
      for (int p = 0; p < 4; p++) begin
        rtci_bus_master_inst.wr(REG_SEC + p[7:0], wv[p]);
      end
      osc(tick);
      cyc(10);
      rchk(REG_DAY, dexp[i]);
      rchk(REG_HOUR, 8'h00);
    end
    chk(8'h01, wraps[7:0]);
    // a tick during a read is held back, then applied
    fork
      rtci_bus_master_inst.rd(REG_SEC, q);
      begin
        cyc(400);
        osc(tick);
      end
    join
    chk(8'h00, q);
    cyc(10);
    rchk(REG_SEC, 8'h01);
    // burst read: the pointer steps from hours to day
    rtci_bus_master_inst.rd2(REG_HOUR, b2);
    chk(8'h00, b2[15:8]);
    chk(8'h01, b2[7:0]);
    // mid-run reset brings back the start-up values
    i_nrst = 1'b0;
    cyc(10);
    i_nrst = 1'b1;
    cyc(20);
    chk(8'h00, {7'h00, int_oe});
    rchk(REG_SEC, 8'h80);
    rchk(REG_DAY, 8'h00);
    tally_and_finish();
  end
endmodule
